// *** include/bckreg_cfg.svh ***
// Constants for the buck converter control register bank
// Notes on behaviour
// - Pin scaling enable hands converter one scaling to pins and forces table.
// - Two-bit window code picks 500, 600 or 700 mV floor, 32 steps.
// - Three-bit step time field in bits 4..2 sets slew through steps.
// - Converter one bit 1: zero auto modulation switching, one forced PWM.
// - Converter two bit 1 selects auto switching or forced PWM likewise.
// - Both registers return to defaults on power-on reset, some configurable.
// - Configuration select pin level picks which stored default set loads.
`ifndef BCKREG_CFG_SVH
`define BCKREG_CFG_SVH

// ----------------------------------------------------------------------------
// Register indices and address and register widths
// ----------------------------------------------------------------------------
`define BCKREG_IDX_ONE        8'h00
`define BCKREG_IDX_TWO        8'h01
`define BCKREG_IDX_STATUS     8'h02
`define BCKREG_ADDR_W         8
`define BCKREG_REG_W          8

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define BCKREG_BIT_PIN_EN     7
`define BCKREG_BIT_WIN_HI     6
`define BCKREG_BIT_WIN_LO     5
`define BCKREG_BIT_STEP_HI    4
`define BCKREG_BIT_STEP_LO    2
`define BCKREG_BIT_MODE       1

// Writable bits per register
`define BCKREG_MASK_ONE       8'hfe
`define BCKREG_MASK_TWO       8'h1e

// ----------------------------------------------------------------------------
// Reset values and stored default sets
// ----------------------------------------------------------------------------
`define BCKREG_RST_ONE        8'h00
`define BCKREG_RST_TWO        8'h00
`define BCKREG_DEF_ONE_LOW    8'h02
`define BCKREG_DEF_ONE_HIGH   8'h02
`define BCKREG_DEF_TWO_LOW    8'h00
`define BCKREG_DEF_TWO_HIGH   8'h00

// ----------------------------------------------------------------------------
// Scaling window floors in 12.5 mV steps
// ----------------------------------------------------------------------------
`define BCKREG_FLOOR_500      7'h28
`define BCKREG_FLOOR_600      7'h30
`define BCKREG_FLOOR_700      7'h38
`define BCKREG_WIN_SPAN       7'h1f

// ----------------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------------
// Edges after release before the strap synchroniser holds the pin level
`define BCKREG_SYNC_FILL      2'h3

`endif

// *** include/bckreg_pkg.sv ***
// Types for the buck converter control register bank
package bckreg_pkg;
  typedef enum logic [1:0] {
    bckreg_boot_sync,
    bckreg_boot_load,
    bckreg_run
  } bckreg_state_e;

  typedef logic [7:0] bckreg_byte_t;
endpackage

// *** logic/bckreg_top.sv ***
// AHB-Lite register bank for buck converter one and two control
`include "bckreg_cfg.svh"

module bckreg_top
  import bckreg_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        config_select_pin,
  input  wire logic        scaling_pulse_pin,
  input  wire logic        scaling_clock_pin,
  output logic             pin_scaling_enable,
  output logic      [1:0]  pin_scaling_window,
  output logic      [6:0]  window_floor_step,
  output logic      [6:0]  window_ceiling_step,
  output logic             table_forced,
  output logic             scaling_pulse,
  output logic             scaling_clock,
  output logic      [2:0]  buck_one_step_time_select,
  output logic             buck_one_modulation_select,
  output logic      [2:0]  buck_two_step_time_select,
  output logic             buck_two_modulation_select
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  bckreg_state_e state;
  bckreg_byte_t  buck_one_control;
  bckreg_byte_t  buck_two_control;
  logic [2:0]    cfg_sync;
  logic [1:0]    pulse_sync;
  logic [1:0]    clock_sync;
  logic          cfg_level;
  logic [1:0]    fill_cnt;
  logic          wr_pend;
  logic [7:0]    wr_idx;
  logic          take;
  logic [7:0]    take_idx;
  bckreg_byte_t  rd_val;
  logic [6:0]    next_floor;

  // Address phase is taken only when the bus is ready and a transfer starts
  assign take     = hsel & htrans[1] & hready;
  assign take_idx = haddr[`BCKREG_ADDR_W+1:2];

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  // Two stages per scaling pin, three for the strap; the strap's third stage feeds only the settle check
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_sync   <= 3'h0;
      pulse_sync <= 2'h0;
      clock_sync <= 2'h0;
    end else begin
      cfg_sync   <= {cfg_sync[1:0], config_select_pin};
      pulse_sync <= {pulse_sync[0], scaling_pulse_pin};
      clock_sync <= {clock_sync[0], scaling_clock_pin};
    end
  end

  // --------------------------------------------------------------------------
  // Boot sequencer
  // --------------------------------------------------------------------------
  // Counts the edges the strap needs to cross the synchroniser; the stages
  // hold zero in reset, so their agreement alone proves nothing yet
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fill_cnt <= 2'h0;
    end else if (state == bckreg_boot_sync &&
                 fill_cnt != `BCKREG_SYNC_FILL) begin
      fill_cnt <= fill_cnt + 2'h1;
    end
  end

  // The strap is caught once it has settled through the synchroniser;
  // the bus is held off until the defaults are in place
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= bckreg_boot_sync;
    end else begin
      case (state)
        bckreg_boot_sync: begin
          if (fill_cnt == `BCKREG_SYNC_FILL &&
              cfg_sync[2] == cfg_sync[1]) begin
            state <= bckreg_boot_load;
          end
        end
        bckreg_boot_load: begin
          state <= bckreg_run;
        end
        bckreg_run: begin
          state <= bckreg_run;
        end
        default: begin
          state <= bckreg_boot_sync;
        end
      endcase
    end
  end

  // Ready rises with the default load and stays up until the next reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
    end else begin
      hreadyout <= (state == bckreg_boot_load) || (state == bckreg_run);
    end
  end

  // Strap level kept for the status word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_level <= 1'b0;
    end else if (state == bckreg_boot_load) begin
      cfg_level <= cfg_sync[1];
    end
  end

  // --------------------------------------------------------------------------
  // Write capture
  // --------------------------------------------------------------------------
  // Writes land in the data phase, when hwdata is valid
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
    end else begin
      wr_pend <= take & hwrite;
    end
  end

  // Index follows every cycle; only wr_pend gives it meaning
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_idx <= 8'h00;
    end else begin
      wr_idx <= take_idx;
    end
  end

  // --------------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------------
  // Converter one register; the boot load wins over a pending write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buck_one_control <= `BCKREG_RST_ONE;
    end else if (state == bckreg_boot_load) begin
      buck_one_control <= cfg_sync[1] ? `BCKREG_DEF_ONE_HIGH
                                      : `BCKREG_DEF_ONE_LOW;
    end else if (wr_pend && wr_idx == `BCKREG_IDX_ONE) begin
      buck_one_control <= hwdata[7:0] & `BCKREG_MASK_ONE;
    end
  end

  // Converter two register; its unused bits can never be set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buck_two_control <= `BCKREG_RST_TWO;
    end else if (state == bckreg_boot_load) begin
      buck_two_control <= cfg_sync[1] ? `BCKREG_DEF_TWO_HIGH
                                      : `BCKREG_DEF_TWO_LOW;
    end else if (wr_pend && wr_idx == `BCKREG_IDX_TWO) begin
      buck_two_control <= hwdata[7:0] & `BCKREG_MASK_TWO;
    end
  end

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  // readback of current bits
  always_comb begin
    case (take_idx)
      `BCKREG_IDX_ONE:    rd_val = buck_one_control;
      `BCKREG_IDX_TWO:    rd_val = buck_two_control;
      `BCKREG_IDX_STATUS: rd_val = {6'h00, cfg_level,
                                    state == bckreg_run};
      default:            rd_val = 8'h00;
    endcase
  end

  // Read data is registered so it stands for the whole data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata <= {24'h00_0000, rd_val};
    end
  end

  // Every transfer is accepted, so the response never leaves OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Converter one scaling window
  // --------------------------------------------------------------------------
  // window floor per code
  always_comb begin
    case (buck_one_control[`BCKREG_BIT_WIN_HI:`BCKREG_BIT_WIN_LO])
      2'h1:    next_floor = `BCKREG_FLOOR_700;
      2'h2:    next_floor = `BCKREG_FLOOR_600;
      default: next_floor = `BCKREG_FLOOR_500;
    endcase
  end

  // --------------------------------------------------------------------------
  // Converter one pin scaling hand-over
  // --------------------------------------------------------------------------
  // Pin levels are gated here so the converter never sees a stray pin edge
  // while its own voltage registers are in charge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_scaling_enable <= 1'b0;
      table_forced       <= 1'b0;
      scaling_pulse      <= 1'b0;
      scaling_clock      <= 1'b0;
    end else begin
      pin_scaling_enable <= buck_one_control[`BCKREG_BIT_PIN_EN];
      table_forced       <= buck_one_control[`BCKREG_BIT_PIN_EN];
      scaling_pulse      <= pulse_sync[1] &
                            buck_one_control[`BCKREG_BIT_PIN_EN];
      scaling_clock      <= clock_sync[1] &
                            buck_one_control[`BCKREG_BIT_PIN_EN];
    end
  end

  // --------------------------------------------------------------------------
  // Converter one scaling window outputs
  // --------------------------------------------------------------------------
  // Floor and ceiling come precomputed so the converter needs no adder
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_scaling_window  <= 2'h0;
      window_floor_step   <= `BCKREG_FLOOR_500;
      window_ceiling_step <= `BCKREG_FLOOR_500 + `BCKREG_WIN_SPAN;
    end else begin
      pin_scaling_window  <=
        buck_one_control[`BCKREG_BIT_WIN_HI:`BCKREG_BIT_WIN_LO];
      window_floor_step   <= next_floor;
      window_ceiling_step <= next_floor + `BCKREG_WIN_SPAN;
    end
  end

  // --------------------------------------------------------------------------
  // Step time outputs
  // --------------------------------------------------------------------------
  // Registered copies keep every output straight from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buck_one_step_time_select <= 3'h0;
      buck_two_step_time_select <= 3'h0;
    end else begin
      buck_one_step_time_select <=
        buck_one_control[`BCKREG_BIT_STEP_HI:`BCKREG_BIT_STEP_LO];
      buck_two_step_time_select <=
        buck_two_control[`BCKREG_BIT_STEP_HI:`BCKREG_BIT_STEP_LO];
    end
  end

  // --------------------------------------------------------------------------
  // Modulation select outputs
  // --------------------------------------------------------------------------
  // Low means automatic switching, high means forced PWM
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buck_one_modulation_select <= 1'b0;
      buck_two_modulation_select <= 1'b0;
    end else begin
      buck_one_modulation_select <= buck_one_control[`BCKREG_BIT_MODE];
      buck_two_modulation_select <= buck_two_control[`BCKREG_BIT_MODE];
    end
  end

endmodule

// *** tb/bckreg_monitor.sv ***
// Checker for the buck converter control register bank ports
module bckreg_monitor (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        scaling_pulse_pin,
  input wire logic        pin_scaling_enable,
  input wire logic [1:0]  pin_scaling_window,
  input wire logic [6:0]  window_floor_step,
  input wire logic [6:0]  window_ceiling_step,
  input wire logic        table_forced,
  input wire logic        scaling_pulse,
  input wire logic [2:0]  buck_one_step_time_select,
  input wire logic        buck_one_modulation_select,
  input wire logic [2:0]  buck_two_step_time_select,
  input wire logic        buck_two_modulation_select
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [7:0] wd_lo;
  logic [6:0] floor_exp;
  // Low byte only, so $past sees a plain signal
  assign wd_lo = hwdata[7:0];
  // Window floor in 12.5 mV units; code 3 reads as the lowest
  always_comb begin
    case (pin_scaling_window)
      2'h1:    floor_exp = 7'h38;
      2'h2:    floor_exp = 7'h30;
      default: floor_exp = 7'h28;
    endcase
  end
  // Write address phase followed by its data phase
  sequence wr_one_s;
    hsel && htrans[1] && hready && hwrite && haddr[9:2] == 8'h00 ##1 1'b1;
  endsequence
  sequence wr_two_s;
    hsel && htrans[1] && hready && hwrite && haddr[9:2] == 8'h01 ##1 1'b1;
  endsequence
  table_link_a: assert property (table_forced == pin_scaling_enable)
    else $error("table force differs from pin scaling enable");
  pulse_gate_a: assert property (scaling_pulse |-> pin_scaling_enable)
    else $error("scaling pulse passed while pin scaling is off");
  pulse_follow_a: assert property (pin_scaling_enable &&
    $past(pin_scaling_enable, 3) |->
    scaling_pulse == $past(scaling_pulse_pin, 3))
    else $error("scaling pulse does not follow its pin");
  window_floor_a: assert property (window_floor_step == floor_exp)
    else $error("window floor wrong for window code");
  window_span_a: assert property (
    window_ceiling_step == window_floor_step + 7'h1f)
    else $error("window does not span 32 steps");
  one_fields_a: assert property (wr_one_s |-> ##2
    {pin_scaling_enable, pin_scaling_window, buck_one_step_time_select,
     buck_one_modulation_select} == $past(wd_lo[7:1], 2))
    else $error("converter one fields do not follow write");
  two_fields_a: assert property (wr_two_s |-> ##2
    {buck_two_step_time_select, buck_two_modulation_select}
      == $past(wd_lo[4:1], 2))
    else $error("converter two fields do not follow write");
  resp_okay_a: assert property (hresp == 1'b0 && hrdata[31:8] == 24'h0)
    else $error("error response or upper read bits set");
  ready_keep_a: assert property (hreadyout |=> hreadyout)
    else $error("ready dropped after boot");
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the buck converter control register bank
module tb_top
  import bckreg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, config_select_pin;
  logic scaling_pulse_pin, scaling_clock_pin, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, pin_scaling_window;
  logic [2:0] hsize, buck_one_step_time_select, buck_two_step_time_select;
  logic [6:0] window_floor_step, window_ceiling_step;
  logic pin_scaling_enable, table_forced, scaling_pulse, scaling_clock;
  logic buck_one_modulation_select, buck_two_modulation_select;
  int error_cnt = 0;
  int total_checks = 0;
  bckreg_byte_t fexp;
  bckreg_top u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .config_select_pin, .scaling_pulse_pin, .scaling_clock_pin,
    .pin_scaling_enable, .pin_scaling_window, .window_floor_step,
    .window_ceiling_step, .table_forced, .scaling_pulse, .scaling_clock,
    .buck_one_step_time_select, .buck_one_modulation_select,
    .buck_two_step_time_select, .buck_two_modulation_select);
  // 25 MHz bus clock
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  task automatic report_and_stop;
    if (error_cnt == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Cuts a hung wait short; the whole sequence needs about 7 us
  initial begin
    #200us;
    error_cnt++;
    report_and_stop();
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Waits for the edge at which ready is seen high
  task automatic wait_rdy;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  // One AHB single word transfer, address phase then data phase
  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= 3'h2;
    haddr  <= {22'h0, idx, 2'h0};
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  // Idle slot after a write keeps a read from racing the store
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    xfer(1'b1, idx, d);
    @(posedge hclk);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask
  task automatic do_reset(input logic lvl);
    hresetn           <= 1'b0;
    hsel              <= 1'b0;
    htrans            <= 2'h0;
    config_select_pin <= lvl;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    wait_rdy();
  endtask
  initial begin
    {hresetn, hsel, hwrite, config_select_pin} = 4'h0;
    {scaling_pulse_pin, scaling_clock_pin, htrans, hsize} = 7'h0;
    haddr  = 32'h0;
    hwdata = 32'h0;
    do_reset(1'b0);
    rdc(8'h00, 32'h02);
    rdc(8'h01, 32'h00);
    rdc(8'h02, 32'h01);
    wr(8'h00, 32'hffffffff);
    rdc(8'h00, 32'hfe);
    wr(8'h01, 32'hffffffff);
    rdc(8'h01, 32'h1e);
    chk({buck_two_step_time_select, buck_two_modulation_select}, 4'hf);
    // Every window code, step time and mode on both converters
    for (int i = 0; i < 8; i++) begin
      wr(8'h00, {24'h0, 1'b1, i[1:0], i[2:0], i[0], 1'b0});
      wr(8'h01, {27'h0, ~i[2:0], i[1], 1'b0});
      repeat (3) @(posedge hclk);
      fexp = (i[1:0] == 2'h1) ? 8'h38 : (i[1:0] == 2'h2) ? 8'h30 : 8'h28;
      chk(window_floor_step, fexp);
      chk(window_ceiling_step, fexp + 8'h1f);
      chk({buck_one_step_time_select, buck_one_modulation_select},
          {i[2:0], i[0]});
      chk({buck_two_step_time_select, buck_two_modulation_select},
          {~i[2:0], i[1]});
      chk({pin_scaling_enable, table_forced}, 2'h3);
    end
    // Pins reach the converter only while pin scaling is on
    scaling_pulse_pin <= 1'b1;
    scaling_clock_pin <= 1'b1;
    repeat (5) @(posedge hclk);
    chk({scaling_pulse, scaling_clock}, 2'h3);
    wr(8'h00, 32'h0);
    repeat (3) @(posedge hclk);
    chk({scaling_pulse, scaling_clock, table_forced}, 3'h0);
    wr(8'h03, 32'hffffffff);
    rdc(8'h03, 32'h0);
    rdc(8'h00, 32'h0);
    do_reset(1'b1);
    rdc(8'h00, 32'h02);
    rdc(8'h01, 32'h00);
    rdc(8'h02, 32'h03);
    report_and_stop();
  end
endmodule
bind bckreg_top bckreg_monitor u_mon (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
  .scaling_pulse_pin, .pin_scaling_enable, .pin_scaling_window,
  .window_floor_step, .window_ceiling_step, .table_forced, .scaling_pulse,
  .buck_one_step_time_select, .buck_one_modulation_select,
  .buck_two_step_time_select, .buck_two_modulation_select);
